// *** inc/io_line_pkg.sv ***
// Constants, selector codes and command selects for the I/O line and PWM block.
package io_line_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PWM_PERIOD_NS = 64000;
    localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS * 1000 / CLK_PERIOD_PS;
    localparam int HOLD_UNIT_MS = 100;
    localparam int HOLD_UNIT_CYC = HOLD_UNIT_MS * 1000000 / CLK_PERIOD_PS;
    localparam int BLINK_UNIT_MS = 10;
    localparam int BLINK_UNIT_CYC = BLINK_UNIT_MS * 1000000 / CLK_PERIOD_PS;
    localparam int BLINK_SLEEP_COORD_MS = 500;
    localparam int BLINK_OTHER_MS = 250;
    localparam logic [7:0] BLINK_SLEEP_COORD_UNITS = 8'(BLINK_SLEEP_COORD_MS / BLINK_UNIT_MS);
    localparam logic [7:0] BLINK_OTHER_UNITS = 8'(BLINK_OTHER_MS / BLINK_UNIT_MS);
    localparam logic [7:0] BLINK_MIN = 8'h14;
    localparam logic [9:0] PWM_STEPS = 10'h3ff;
    localparam logic [7:0] HOLD_FOREVER = 8'hff;
    // Command selects on the command port.
    localparam logic [3:0] SEL_LINE11_FUNC = 4'h0;
    localparam logic [3:0] SEL_LINE12_FUNC = 4'h1;
    localparam logic [3:0] SEL_PULL_EN = 4'h2;
    localparam logic [3:0] SEL_PULL_DIR = 4'h3;
    localparam logic [3:0] SEL_PWM_A_DUTY = 4'h4;
    localparam logic [3:0] SEL_PWM_B_DUTY = 4'h5;
    localparam logic [3:0] SEL_HOLD = 4'h6;
    localparam logic [3:0] SEL_BLINK = 4'h7;
    localparam logic [3:0] SEL_APPLY = 4'h8;
    localparam logic [3:0] SEL_SAMPLE = 4'h9;
    // Reset values.
    localparam logic [2:0] FUNC_RESET = 3'h0;
    localparam logic [19:0] PULL_RESET = 20'h0ffff;
    localparam logic [9:0] DUTY_RESET = 10'h000;
    localparam logic [7:0] HOLD_RESET = 8'h28;
    localparam logic [7:0] BLINK_RESET = 8'h00;
    // Line function selector codes.
    localparam logic [2:0] FN_DISABLED = 3'h0;
    localparam logic [2:0] FN_SPECIAL = 3'h1;
    localparam logic [2:0] FN_PWM = 3'h2;
    localparam logic [2:0] FN_INPUT = 3'h3;
    localparam logic [2:0] FN_OUT_LOW = 3'h4;
    localparam logic [2:0] FN_OUT_HIGH = 3'h5;
    localparam logic [63:0] LP_ANY = 64'h0000_0000_0000_ffff;
    localparam logic [63:0] LP_OFF = 64'hffff_ffff_ffff_ffff;
    localparam logic [1:0] AO_STANDARD = 2'h2;
    localparam logic [1:0] AP_FRAMED = 2'h1;
endpackage : io_line_pkg

// *** core/io_line_pwm_config.sv ***
// I/O line function select, pull masks, two PWM outputs, signal-strength hold, LED blink and sampling.
module io_line_pwm_config import io_line_pkg::*; #(
    parameter bit THROUGH_HOLE = 1'b0,
    parameter int PWM_PERIOD_CYCLES = PWM_PERIOD_CYC,
    parameter int HOLD_UNIT_CYCLES = HOLD_UNIT_CYC,
    parameter int BLINK_UNIT_CYCLES = BLINK_UNIT_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [3:0] cmd_sel,
    input wire logic [19:0] cmd_wdata,
    input wire logic cmd_remote,
    output logic resp_valid,
    output logic resp_ok,
    output logic [19:0] resp_rdata,
    input wire logic [2:0] line10_function_select,
    input wire logic [1:0] output_option_select,
    input wire logic [1:0] framed_interface_mode,
    input wire logic [63:0] line_passing_source_address,
    input wire logic [63:0] dest_addr,
    input wire logic [19:0] other_line_passive,
    input wire logic [14:0] other_line_configured,
    input wire logic [3:0] analog_enabled,
    input wire logic [14:0] other_dio_level,
    input wire logic lp_valid,
    input wire logic [63:0] lp_src_addr,
    input wire logic lp_ch0_present,
    input wire logic [9:0] lp_ch0_value,
    input wire logic lp_ch1_present,
    input wire logic [9:0] lp_ch1_value,
    input wire logic rx_packet,
    input wire logic [9:0] rx_strength_duty,
    input wire logic assoc_indicator_enable,
    input wire logic network_joined,
    input wire logic sleep_coordinator,
    input wire logic spi_data_out,
    input wire logic first_pwm_output_in,
    input wire logic line_eleven_in,
    input wire logic line_twelve_in,
    output logic first_pwm_output_out,
    output logic first_pwm_output_oe,
    output logic line_eleven_out,
    output logic line_eleven_oe,
    output logic line_twelve_out,
    output logic line_twelve_oe,
    output logic [19:0] pull_enable,
    output logic [19:0] pull_up,
    output logic assoc_led,
    output logic sample_valid,
    output logic sample_to_serial,
    output logic sample_to_requester,
    output logic sample_extended,
    output logic sample_framed,
    output logic [63:0] sample_dest_addr,
    output logic [14:0] sample_dio_mask,
    output logic [3:0] sample_aio_mask,
    output logic [14:0] sample_dio_data
);
    localparam int MASK_W = THROUGH_HOLE ? 16 : 20;
    localparam logic [19:0] MASK_KEEP = 20'((64'h1 << MASK_W) - 64'h1);

    // Mask bit that controls a given line number.
    function automatic logic [4:0] line_to_bit(input int line);
        case (line)
            4: line_to_bit = 5'd0;
            3: line_to_bit = 5'd1;
            2: line_to_bit = 5'd2;
            1: line_to_bit = 5'd3;
            0: line_to_bit = 5'd4;
            6: line_to_bit = 5'd5;
            8: line_to_bit = 5'd6;
            14: line_to_bit = 5'd7;
            5: line_to_bit = 5'd8;
            9: line_to_bit = 5'd9;
            12: line_to_bit = 5'd10;
            10: line_to_bit = 5'd11;
            11: line_to_bit = 5'd12;
            7: line_to_bit = 5'd13;
            13: line_to_bit = 5'd14;
            default: line_to_bit = 5'(line);
        endcase
    endfunction : line_to_bit

    function automatic logic fn_passive(input logic [2:0] fn);
        fn_passive = (fn == FN_DISABLED) || (fn == FN_INPUT);
    endfunction : fn_passive

    function automatic logic fn_configured(input logic [2:0] fn);
        fn_configured = (fn >= FN_PWM) && (fn <= FN_OUT_HIGH);
    endfunction : fn_configured

    // Pending copies are what the host writes; active copies steer the pins.
    logic [2:0] p11_r, p12_r, a11_r, a12_r;
    logic [19:0] pen_r, pdir_r, apen_r, apdir_r;
    logic [9:0] pduty_a_r, pduty_b_r, duty_a_r, duty_b_r;
    logic [7:0] phold_r, hold_r, pblink_r, blink_r;
    logic resp_valid_r, resp_ok_r;
    logic [19:0] resp_rdata_r;

    // Pin inputs pass two flip-flops before anything reads them.
    logic [2:0] pin_meta_r, pin_sync_r;

    wire wr = cmd_valid && cmd_write;
    wire rd = cmd_valid && !cmd_write;
    wire apply = cmd_valid && (cmd_sel == SEL_APPLY);
    wire sample_cmd = cmd_valid && (cmd_sel == SEL_SAMPLE);
    wire [2:0] wfn = cmd_wdata[2:0];
    wire fn_legal = (cmd_wdata[19:3] == 17'h0) && (wfn <= FN_OUT_HIGH);
    wire p11_ok = fn_legal && (wfn != FN_SPECIAL);
    wire p12_ok = fn_legal && (wfn != FN_PWM) && (THROUGH_HOLE || (wfn != FN_SPECIAL));
    wire duty_ok = cmd_wdata[19:10] == 10'h0;
    wire hold_ok = cmd_wdata[19:8] == 12'h0;
    wire blink_ok = hold_ok && ((cmd_wdata[7:0] == 8'h0) || (cmd_wdata[7:0] >= BLINK_MIN));
    wire [19:0] mask_w = cmd_wdata & MASK_KEEP;

    // Line-passing acceptance: all-ones disables, 0xffff takes any source.
    wire lp_enabled = line_passing_source_address != LP_OFF;
    wire lp_match = lp_valid && lp_enabled &&
        ((line_passing_source_address == LP_ANY) || (lp_src_addr == line_passing_source_address));
    wire lp_a = lp_match && lp_ch0_present && (line10_function_select == FN_PWM);
    wire lp_b = lp_match && lp_ch1_present && (a11_r == FN_PWM);

    wire any_configured = fn_configured(line10_function_select) || fn_configured(a11_r) ||
        fn_configured(a12_r) || (other_line_configured != 15'h0) || (analog_enabled != 4'h0);
    wire sample_ok = any_configured;

    logic [19:0] rdata_sel;
    logic wr_ok;
    always_comb begin
        rdata_sel = 20'h0;
        wr_ok = 1'b0;
        case (cmd_sel)
            SEL_LINE11_FUNC: begin
                rdata_sel = {17'h0, p11_r};
                wr_ok = p11_ok;
            end
            SEL_LINE12_FUNC: begin
                rdata_sel = {17'h0, p12_r};
                wr_ok = p12_ok;
            end
            SEL_PULL_EN: begin
                rdata_sel = pen_r;
                wr_ok = 1'b1;
            end
            SEL_PULL_DIR: begin
                rdata_sel = pdir_r;
                wr_ok = 1'b1;
            end
            SEL_PWM_A_DUTY: begin
                rdata_sel = {10'h0, pduty_a_r};
                wr_ok = duty_ok;
            end
            SEL_PWM_B_DUTY: begin
                rdata_sel = {10'h0, pduty_b_r};
                wr_ok = duty_ok;
            end
            SEL_HOLD: begin
                rdata_sel = {12'h0, phold_r};
                wr_ok = hold_ok;
            end
            SEL_BLINK: begin
                rdata_sel = {12'h0, pblink_r};
                wr_ok = blink_ok;
            end
            SEL_APPLY: wr_ok = 1'b1;
            SEL_SAMPLE: wr_ok = sample_ok;
            default: wr_ok = 1'b0;
        endcase
    end

    wire do_wr = wr && wr_ok;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            p11_r <= FUNC_RESET;
            p12_r <= FUNC_RESET;
            pen_r <= PULL_RESET;
            pdir_r <= PULL_RESET;
            pduty_a_r <= DUTY_RESET;
            pduty_b_r <= DUTY_RESET;
            phold_r <= HOLD_RESET;
            pblink_r <= BLINK_RESET;
        end else if (do_wr) begin
            if (cmd_sel == SEL_LINE11_FUNC) p11_r <= wfn;
            if (cmd_sel == SEL_LINE12_FUNC) p12_r <= wfn;
            if (cmd_sel == SEL_PULL_EN) pen_r <= mask_w;
            if (cmd_sel == SEL_PULL_DIR) pdir_r <= mask_w;
            if (cmd_sel == SEL_PWM_A_DUTY) pduty_a_r <= cmd_wdata[9:0];
            if (cmd_sel == SEL_PWM_B_DUTY) pduty_b_r <= cmd_wdata[9:0];
            if (cmd_sel == SEL_HOLD) phold_r <= cmd_wdata[7:0];
            if (cmd_sel == SEL_BLINK) pblink_r <= cmd_wdata[7:0];
        end
    end

    // Passed samples win over an apply landing in the same cycle, so a fresh value is never lost.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            a11_r <= FUNC_RESET;
            a12_r <= FUNC_RESET;
            apen_r <= PULL_RESET;
            apdir_r <= PULL_RESET;
            duty_a_r <= DUTY_RESET;
            duty_b_r <= DUTY_RESET;
            hold_r <= HOLD_RESET;
            blink_r <= BLINK_RESET;
        end else begin
            if (apply) begin
                a11_r <= p11_r;
                a12_r <= p12_r;
                apen_r <= pen_r;
                apdir_r <= pdir_r;
                duty_a_r <= pduty_a_r;
                duty_b_r <= pduty_b_r;
                hold_r <= phold_r;
                blink_r <= pblink_r;
            end
            if (lp_a) duty_a_r <= lp_ch0_value;
            if (lp_b) duty_b_r <= lp_ch1_value;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            resp_valid_r <= 1'b0;
            resp_ok_r <= 1'b0;
            resp_rdata_r <= 20'h0;
        end else begin
            resp_valid_r <= cmd_valid;
            resp_ok_r <= cmd_valid && ((rd && !sample_cmd) || wr_ok);
            resp_rdata_r <= rd ? rdata_sel : 20'h0;
        end
    end

    assign resp_valid = resp_valid_r;
    assign resp_ok = resp_ok_r;
    assign resp_rdata = resp_rdata_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end else begin
            pin_meta_r <= {line_twelve_in, line_eleven_in, first_pwm_output_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    // Pull outputs per line number; line 10 uses the line10_function_select input, lines 11 and 12 this block's own selectors.
    logic [19:0] passive;
    always_comb begin
        passive = other_line_passive;
        passive[10] = fn_passive(line10_function_select);
        passive[11] = fn_passive(a11_r);
        passive[12] = fn_passive(a12_r);
    end

    genvar gl;
    generate
        for (gl = 0; gl < 20; gl++) begin : g_pull
            localparam logic [4:0] B = line_to_bit(gl);
            assign pull_enable[gl] = passive[gl] && apen_r[B];
            assign pull_up[gl] = passive[gl] && apen_r[B] && apdir_r[B];
        end
    endgenerate

    // PWM period position; high while position * 1023 / period is below the duty.
    logic [15:0] pwm_cnt_r;
    always_ff @(posedge core_clk) begin
        if (rst) pwm_cnt_r <= 16'h0;
        else if (pwm_cnt_r == 16'(PWM_PERIOD_CYCLES - 1)) pwm_cnt_r <= 16'h0;
        else pwm_cnt_r <= pwm_cnt_r + 16'h1;
    end

    function automatic logic pwm_level(input logic [15:0] pos, input logic [9:0] duty);
        pwm_level = (32'(pos) * 32'(PWM_STEPS)) < (32'(duty) * 32'(PWM_PERIOD_CYCLES));
    endfunction : pwm_level

    // Signal-strength duty and hold timer.
    logic [9:0] rssi_duty_r;
    logic [7:0] hold_cnt_r;
    logic rssi_on_r;
    logic [31:0] hold_tick_r;
    wire rssi_mode = line10_function_select == FN_SPECIAL;
    wire hold_tick = hold_tick_r == 32'(HOLD_UNIT_CYCLES - 1);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rssi_duty_r <= DUTY_RESET;
            hold_cnt_r <= 8'h0;
            rssi_on_r <= 1'b0;
            hold_tick_r <= 32'h0;
        end else if (rssi_mode && rx_packet) begin
            rssi_duty_r <= rx_strength_duty;
            hold_cnt_r <= hold_r;
            rssi_on_r <= hold_r != 8'h0;
            hold_tick_r <= 32'h0;
        end else if (!rssi_mode) begin
            rssi_on_r <= 1'b0;
            hold_tick_r <= 32'h0;
        end else if (rssi_on_r && (hold_cnt_r != HOLD_FOREVER)) begin
            hold_tick_r <= hold_tick ? 32'h0 : hold_tick_r + 32'h1;
            if (hold_tick) begin
                hold_cnt_r <= hold_cnt_r - 8'h1;
                if (hold_cnt_r == 8'h1) rssi_on_r <= 1'b0;
            end
        end
    end

    logic pwm_a_r, pwm_b_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwm_a_r <= 1'b0;
            pwm_b_r <= 1'b0;
        end else begin
            pwm_a_r <= rssi_mode ? (rssi_on_r && pwm_level(pwm_cnt_r, rssi_duty_r)) :
                pwm_level(pwm_cnt_r, duty_a_r);
            pwm_b_r <= pwm_level(pwm_cnt_r, duty_b_r);
        end
    end

    assign first_pwm_output_oe = rssi_mode || (line10_function_select inside {FN_PWM, FN_OUT_LOW, FN_OUT_HIGH});
    assign first_pwm_output_out = (rssi_mode || line10_function_select == FN_PWM) ? pwm_a_r :
        (line10_function_select == FN_OUT_HIGH);
    assign line_eleven_oe = a11_r inside {FN_PWM, FN_OUT_LOW, FN_OUT_HIGH};
    assign line_eleven_out = (a11_r == FN_PWM) ? pwm_b_r : (a11_r == FN_OUT_HIGH);
    assign line_twelve_oe = (a12_r == FN_OUT_LOW) || (a12_r == FN_OUT_HIGH) ||
        (THROUGH_HOLE && (a12_r == FN_SPECIAL));
    assign line_twelve_out = (a12_r == FN_SPECIAL) ? spi_data_out : (a12_r == FN_OUT_HIGH);

    // Association blink: both half-periods equal the programmed count of 10 ms units; a count of zero gives 500 ms on a sleep coordinator, else 250 ms.
    logic [31:0] blink_tick_r;
    logic [7:0] blink_units_r;
    logic led_r;
    wire blink_run = assoc_indicator_enable && network_joined;
    wire blink_tick = blink_tick_r == 32'(BLINK_UNIT_CYCLES - 1);
    wire [7:0] half = (blink_r == 8'h0) ?
        (sleep_coordinator ? BLINK_SLEEP_COORD_UNITS : BLINK_OTHER_UNITS) : blink_r;
    always_ff @(posedge core_clk) begin
        if (rst || !blink_run) begin
            blink_tick_r <= 32'h0;
            blink_units_r <= 8'h0;
            led_r <= 1'b0;
        end else begin
            blink_tick_r <= blink_tick ? 32'h0 : blink_tick_r + 32'h1;
            if (blink_tick) begin
                if (blink_units_r + 8'h1 >= half) begin
                    blink_units_r <= 8'h0;
                    led_r <= !led_r;
                end else begin
                    blink_units_r <= blink_units_r + 8'h1;
                end
            end
        end
    end
    assign assoc_led = led_r;

    // Immediate sample capture; the report formatter downstream uses the masks and format flags.
    wire extended = output_option_select != AO_STANDARD;
    logic [14:0] dio_cfg, dio_now;
    always_comb begin
        dio_cfg = other_line_configured;
        dio_cfg[10] = fn_configured(line10_function_select);
        dio_cfg[11] = fn_configured(a11_r);
        dio_cfg[12] = fn_configured(a12_r);
        if (!extended) dio_cfg[14:9] = 6'h0;
        dio_now = other_dio_level;
        dio_now[12:10] = pin_sync_r;
    end

    logic smp_v_r, smp_ser_r, smp_req_r, smp_ext_r, smp_frm_r;
    logic [63:0] smp_dest_r;
    logic [14:0] smp_mask_r, smp_data_r;
    logic [3:0] smp_aio_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            smp_v_r <= 1'b0;
            smp_ser_r <= 1'b0;
            smp_req_r <= 1'b0;
            smp_ext_r <= 1'b0;
            smp_frm_r <= 1'b0;
            smp_dest_r <= 64'h0;
            smp_mask_r <= 15'h0;
            smp_data_r <= 15'h0;
            smp_aio_r <= 4'h0;
        end else begin
            smp_v_r <= sample_cmd && sample_ok;
            if (sample_cmd && sample_ok) begin
                smp_ser_r <= !cmd_remote;
                smp_req_r <= cmd_remote;
                smp_ext_r <= extended;
                smp_frm_r <= framed_interface_mode == AP_FRAMED;
                smp_dest_r <= dest_addr;
                smp_mask_r <= dio_cfg;
                smp_data_r <= dio_now & dio_cfg;
                smp_aio_r <= analog_enabled;
            end
        end
    end

    assign sample_valid = smp_v_r;
    assign sample_to_serial = smp_ser_r;
    assign sample_to_requester = smp_req_r;
    assign sample_extended = smp_ext_r;
    assign sample_framed = smp_frm_r;
    assign sample_dest_addr = smp_dest_r;
    assign sample_dio_mask = smp_mask_r;
    assign sample_aio_mask = smp_aio_r;
    assign sample_dio_data = smp_data_r;
endmodule : io_line_pwm_config

// *** sim/io_line_asserts.sv ***
// Concurrent checks on the ports of the I/O line and PWM block.
module io_line_asserts import io_line_pkg::*; #(
    parameter bit THROUGH_HOLE = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [3:0] cmd_sel,
    input wire logic [19:0] cmd_wdata,
    input wire logic resp_valid,
    input wire logic resp_ok,
    input wire logic [1:0] output_option_select,
    input wire logic line_eleven_oe,
    input wire logic [19:0] pull_enable,
    input wire logic sample_valid,
    input wire logic sample_to_serial,
    input wire logic sample_to_requester,
    input wire logic sample_extended,
    input wire logic [14:0] sample_dio_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire wr = cmd_valid && cmd_write;
    answer_timing_a: assert property (
        cmd_valid |=> resp_valid) else $error("command without answer");
    line11_refuse_a: assert property (
        wr && cmd_sel == SEL_LINE11_FUNC && (cmd_wdata == 20'h1 || cmd_wdata > 20'h5) |=> !resp_ok)
        else $error("bad line eleven code taken");
    line12_refuse_a: assert property (
        wr && cmd_sel == SEL_LINE12_FUNC && (cmd_wdata == 20'h2 || cmd_wdata > 20'h5
        || (cmd_wdata == 20'h1 && !THROUGH_HOLE)) |=> !resp_ok) else $error("bad line twelve code taken");
    duty_range_a: assert property (
        wr && (cmd_sel == SEL_PWM_A_DUTY || cmd_sel == SEL_PWM_B_DUTY) && cmd_wdata > 20'h3ff |=> !resp_ok)
        else $error("oversized duty taken");
    blink_range_a: assert property (
        wr && cmd_sel == SEL_BLINK && cmd_wdata inside {[20'h1:20'h13]} |=> !resp_ok)
        else $error("short blink time taken");
    driven_no_pull_a: assert property (
        line_eleven_oe |-> !pull_enable[11]) else $error("pull on a driven line");
    sample_answer_a: assert property (
        sample_valid |-> resp_valid && resp_ok && $past(cmd_sel) == SEL_SAMPLE) else $error("stray sample");
    sample_route_a: assert property (
        sample_valid |-> sample_to_serial ^ sample_to_requester) else $error("sample route wrong");
    report_format_a: assert property (
        sample_valid |-> sample_extended == ($past(output_option_select) != AO_STANDARD)
        && (sample_extended || sample_dio_mask[14:9] == 6'h0)) else $error("report format wrong");
endmodule : io_line_asserts
bind io_line_pwm_config io_line_asserts #(.THROUGH_HOLE(THROUGH_HOLE)) io_line_asserts_inst (.*);

// *** sim/pin_model.sv ***
// External circuit on lines ten to twelve: the pin wire with the internal pull resistors.
module pin_model (
    input wire logic core_clk,
    input wire logic [2:0] oe,
    input wire logic [2:0] drv,
    input wire logic [2:0] pull_en,
    input wire logic [2:0] pull_up,
    output logic [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] last_r = 3'h0;
    // A floating pin toggles every cycle, so a stale level can never pass for a driven one.
    assign pin = (oe & drv) | (~oe & pull_en & pull_up) | (~oe & ~pull_en & ~last_r);
    always_ff @(posedge core_clk) begin
        last_r <= pin;
    end
endmodule : pin_model

// *** sim/io_line_pwm_config_tb_top.sv ***
// Self-checking bench for the I/O line and PWM block.
module io_line_pwm_config_tb_top import io_line_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_remote = 1'b0, spi_data_out = 1'b0;
    logic lp_valid = 1'b0, lp_ch0_present = 1'b0, lp_ch1_present = 1'b0, rx_packet = 1'b0, sleep_coordinator = 1'b0;
    logic assoc_indicator_enable = 1'b1, network_joined = 1'b1, resp_valid, resp_ok, assoc_led, sample_valid;
    logic sample_to_serial, sample_to_requester, sample_extended, sample_framed, first_pwm_output_in;
    logic first_pwm_output_out, first_pwm_output_oe, line_eleven_in, line_eleven_out, line_eleven_oe;
    logic line_twelve_in, line_twelve_out, line_twelve_oe;
    logic [2:0] line10_function_select = 3'h0, pins;
    logic [1:0] output_option_select = 2'h2, framed_interface_mode = 2'h0;
    logic [3:0] cmd_sel = 4'h0, analog_enabled = 4'h0, sample_aio_mask;
    logic [9:0] lp_ch0_value = 10'h0, lp_ch1_value = 10'h0, rx_strength_duty = 10'h0;
    logic [14:0] other_line_configured = 15'h0, other_dio_level = 15'h0, sample_dio_mask, sample_dio_data;
    logic [19:0] cmd_wdata = 20'h0, other_line_passive = 20'hfffff, resp_rdata, pull_enable, pull_up, rd;
    logic [63:0] line_passing_source_address = LP_OFF, dest_addr = 64'h1234, lp_src_addr = 64'h77, sample_dest_addr;
    int n_fail = 0, total_checks = 0, cyc = 0;
    io_line_pwm_config #(.PWM_PERIOD_CYCLES(100), .HOLD_UNIT_CYCLES(10), .BLINK_UNIT_CYCLES(10))
        io_line_pwm_config_inst (.*);
    pin_model pin_model_inst (.core_clk(core_clk), .oe({line_twelve_oe, line_eleven_oe, first_pwm_output_oe}),
        .drv({line_twelve_out, line_eleven_out, first_pwm_output_out}), .pull_en(pull_enable[12:10]),
        .pull_up(pull_up[12:10]), .pin(pins));
    assign {line_twelve_in, line_eleven_in, first_pwm_output_in} = pins;
    initial forever #4 core_clk = ~core_clk;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    // A hung handshake ends the run here with a mismatch counted.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd(logic [3:0] sel, logic wr, logic [19:0] d, logic ok);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_sel = sel;
        cmd_wdata = d;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        chk("resp_valid", 1, resp_valid);
        chk("resp_ok", ok, resp_ok);
        rd = resp_rdata;
    endtask : cmd
    function automatic int hi(int d);
        hi = 0;
        for (int p = 0; p < 100; p++) hi += int'(p * 1023 < d * 100);
    endfunction : hi
    task automatic pwm_cnt(int b, int exp);
        int n = 0;
        repeat (2) @(negedge core_clk);
        repeat (100) begin
            @(negedge core_clk);
            n += int'(pins[b] === 1'b1);
        end
        chk("pwm high cycles", exp, n);
    endtask : pwm_cnt
    task automatic t_reset();
        cmd(SEL_PULL_EN, 0, 0, 1);
        chk("pull enable reset", 20'h0ffff, rd);
        cmd(SEL_PULL_DIR, 0, 0, 1);
        chk("pull dir reset", 20'h0ffff, rd);
        cmd(SEL_HOLD, 0, 0, 1);
        chk("hold reset", 8'h28, rd);
        cmd(SEL_PWM_B_DUTY, 0, 0, 1);
        chk("duty reset", 0, rd);
        chk("pull lines", 20'h0ffff, pull_up & pull_enable);
    endtask : t_reset
    task automatic t_sample();
        cmd(SEL_SAMPLE, 1, 0, 0);
        chk("sample none", 0, sample_valid);
        {other_line_configured, other_dio_level, analog_enabled, cmd_remote} = {15'h1, 15'h3, 4'h5, 1'b1};
        {output_option_select, framed_interface_mode} = {2'h0, 2'h1};
        cmd(SEL_SAMPLE, 1, 0, 1);
        chk("remote route", 3'h7, {sample_valid, sample_to_requester, sample_framed});
        chk("sample dest", 64'h1234, sample_dest_addr);
        chk("sample capture", {15'h1, 15'h1, 4'h5}, {sample_dio_mask, sample_dio_data, sample_aio_mask});
        output_option_select = 2'h2;
        cmd_remote = 1'b0;
        cmd(SEL_SAMPLE, 1, 0, 1);
        chk("local route", 2'h2, {sample_to_serial, sample_extended});
    endtask : t_sample
    task automatic t_map();
        int map[20] = '{4, 3, 2, 1, 0, 6, 8, 14, 5, 9, 12, 10, 11, 7, 13, 15, 16, 17, 18, 19};
        for (int i = 0; i < 20; i++) begin
            cmd(SEL_PULL_EN, 1, 20'h1 << i, 1);
            cmd(SEL_PULL_DIR, 1, ~(20'h1 << i), 1);
            cmd(SEL_APPLY, 1, 0, 1);
            chk("pull map", 20'h1 << map[i], pull_enable);
            chk("pull down", 0, pull_up[map[i]]);
        end
        cmd(SEL_PULL_EN, 1, 20'hfffff, 1);
    endtask : t_map
    task automatic t_pwm();
        int duty[3] = '{0, 'h1ff, 'h3ff};
        for (int v = 0; v < 8; v++) begin
            cmd(SEL_LINE11_FUNC, 1, 20'(v), v != 1 && v < 6);
            cmd(SEL_LINE12_FUNC, 1, 20'(v), v == 0 || (v > 2 && v < 6));
        end
        cmd(SEL_LINE11_FUNC, 0, 0, 1);
        chk("refused code kept", 3'h5, rd);
        cmd(SEL_PWM_B_DUTY, 1, 20'h400, 0);
        cmd(SEL_BLINK, 1, 20'h13, 0);
        cmd(4'hf, 1, 0, 0);
        cmd(SEL_LINE11_FUNC, 1, 20'h2, 1);
        cmd(SEL_APPLY, 1, 0, 1);
        chk("line twelve high", 1, pins[2]);
        cmd(SEL_PWM_B_DUTY, 1, 20'h3ff, 1);
        pwm_cnt(1, 0);
        foreach (duty[i]) begin
            cmd(SEL_PWM_B_DUTY, 1, 20'(duty[i]), 1);
            cmd(SEL_APPLY, 1, 0, 1);
            pwm_cnt(1, hi(duty[i]));
        end
        line10_function_select = 3'h2;
        line_passing_source_address = LP_ANY;
        {lp_ch0_present, lp_ch0_value, lp_ch1_present, lp_ch1_value} = {1'b1, 10'h100, 1'b1, 10'h1ff};
        lp_valid = 1'b1;
        @(negedge core_clk);
        lp_valid = 1'b0;
        pwm_cnt(1, hi('h1ff));
        pwm_cnt(0, hi('h100));
    endtask : t_pwm
    task automatic pkt(logic [9:0] d);
        rx_strength_duty = d;
        rx_packet = 1'b1;
        @(negedge core_clk);
        rx_packet = 1'b0;
    endtask : pkt
    task automatic t_rssi();
        line10_function_select = 3'h1;
        cmd(SEL_HOLD, 1, 20'h3, 1);
        cmd(SEL_APPLY, 1, 0, 1);
        pkt(10'h3ff);
        repeat (3) @(negedge core_clk);
        chk("strength output on", 1, pins[0]);
        repeat (40) @(negedge core_clk);
        pwm_cnt(0, 0);
        cmd(SEL_HOLD, 1, 20'hff, 1);
        cmd(SEL_APPLY, 1, 0, 1);
        pkt(10'h3ff);
        repeat (2600) @(negedge core_clk);
        pwm_cnt(0, 100);
        pkt(10'h1ff);
        pwm_cnt(0, hi('h1ff));
    endtask : t_rssi
    task automatic half(output int n);
        logic v;
        v = assoc_led;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (assoc_led === v && n < 2000);
    endtask : half
    task automatic t_blink();
        int hx[3] = '{200, 250, 500};
        int n;
        for (int k = 0; k < 3; k++) begin
            sleep_coordinator = k == 2;
            cmd(SEL_BLINK, 1, k == 0 ? 20'h14 : 20'h0, 1);
            cmd(SEL_APPLY, 1, 0, 1);
            half(n);
            half(n);
            chk("blink half period", hx[k], n);
        end
    endtask : t_blink
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_sample();
        t_map();
        t_pwm();
        t_rssi();
        t_blink();
        end_sim();
    end
endmodule : io_line_pwm_config_tb_top
